/* rtl/lcd_cmd_decoder.sv */
// Host command decoder: operand capture, command decode, pointers, modes and data cycles.
`timescale 1ns/1ns
module lcd_cmd_decoder
  import lcd_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        write_n_i,
  input  wire logic        read_n_i,
  input  wire logic        chip_en_n_i,
  input  wire logic        cmd_sel_i,
  input  wire logic [7:0]  db_i,
  output logic [7:0]       db_o,
  output logic             db_oe_n_o,
  output logic [6:0]       cursor_column_o,
  output logic [4:0]       cursor_row_o,
  output logic [15:0]      memory_address_pointer_o,
  output logic [15:0]      text_home_o,
  output logic [15:0]      graphic_home_o,
  output logic             glyph_generator_ext_o,
  output lcd_merge_t       merge_mode_o,
  output logic             text_on_o,
  output logic             graphic_on_o,
  output logic             cursor_on_o,
  output logic             blink_on_o,
  output logic             ram_we_o,
  output logic             ram_re_o,
  output logic [15:0]      ram_addr_o,
  output logic [7:0]       ram_wdata_o,
  input  wire logic [7:0]  ram_rdata_i
);
  lcd_mem_if mem ();

  logic wr_act;
  logic rd_act;
  logic wr_end;
  logic rd_start;
  logic is_cmd;

  // Two-stage synchronisers for the asynchronous host pins.
  logic [3:0]  ctl_s1_q;
  logic [3:0]  ctl_s2_q;
  logic [7:0]  db_s1_q;
  logic [7:0]  db_s2_q;
  logic        wr_prev_q;
  logic        rd_prev_q;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_s1_q  <= 4'hf;
      ctl_s2_q  <= 4'hf;
      db_s1_q   <= 8'h00;
      db_s2_q   <= 8'h00;
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
    end else begin
      ctl_s1_q  <= {write_n_i, read_n_i, chip_en_n_i, cmd_sel_i};
      ctl_s2_q  <= ctl_s1_q;
      db_s1_q   <= db_i;
      db_s2_q   <= db_s1_q;
      wr_prev_q <= wr_act;
      rd_prev_q <= rd_act;
    end
  end

  assign wr_act   = ~ctl_s2_q[3] & ~ctl_s2_q[1];
  assign rd_act   = ~ctl_s2_q[2] & ~ctl_s2_q[1];
  assign is_cmd   = ctl_s2_q[0];
  // Data is taken as the write strobe rises, when the host bus is surely settled.
  assign wr_end   = wr_prev_q & ~wr_act;
  assign rd_start = rd_act & ~rd_prev_q;

  // Operand shift pair: extra operands push older ones out.
  logic [7:0] op1_q;
  logic [7:0] op2_q;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      op1_q <= 8'h00;
      op2_q <= 8'h00;
    end else if (wr_end && !is_cmd) begin
      op1_q <= op2_q;
      op2_q <= db_s2_q;
    end
  end

  logic       cmd_go;
  logic [7:0] cmd;
  logic       busy_q;
  assign cmd_go = wr_end & is_cmd & ~busy_q;
  assign cmd    = db_s2_q;

  // Cursor changes only here; data commands never reach this block.
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cursor_column_o <= 7'h00;
      cursor_row_o    <= 5'h00;
    end else if (cmd_go && cmd == LCD_CMD_CURSOR) begin
      cursor_column_o <= op1_q[LCD_COLUMN_BITS-1:0];
      cursor_row_o    <= op2_q[LCD_ROW_BITS-1:0];
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      text_home_o    <= LCD_ADDR_RESET;
      graphic_home_o <= LCD_ADDR_RESET;
    end else if (cmd_go) begin
      if (cmd == LCD_CMD_TEXT_HOME) begin
        text_home_o <= {op2_q, op1_q};
      end
      if (cmd == LCD_CMD_GFX_HOME) begin
        graphic_home_o <= {op2_q, op1_q};
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      glyph_generator_ext_o <= 1'b0;
      merge_mode_o          <= LCD_MERGE_MODE_OR;
    end else if (cmd_go && cmd[7:4] == LCD_GRP_MODE_SET) begin
      unique case (cmd[2:0])
        LCD_MERGE_OR: begin
          glyph_generator_ext_o <= cmd[LCD_GLYPH_SRC_BIT];
          merge_mode_o          <= LCD_MERGE_MODE_OR;
        end
        LCD_MERGE_XOR: begin
          glyph_generator_ext_o <= cmd[LCD_GLYPH_SRC_BIT];
          merge_mode_o          <= LCD_MERGE_MODE_XOR;
        end
        LCD_MERGE_AND: begin
          glyph_generator_ext_o <= cmd[LCD_GLYPH_SRC_BIT];
          merge_mode_o          <= LCD_MERGE_MODE_AND;
        end
        LCD_MERGE_ATTR: begin
          glyph_generator_ext_o <= cmd[LCD_GLYPH_SRC_BIT];
          merge_mode_o          <= LCD_MERGE_MODE_ATTR;
        end
        default: begin
          // Undefined merge codes are ignored as a whole.
          glyph_generator_ext_o <= glyph_generator_ext_o;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      text_on_o    <= 1'b0;
      graphic_on_o <= 1'b0;
      cursor_on_o  <= 1'b0;
      blink_on_o   <= 1'b0;
    end else if (cmd_go && cmd[7:4] == LCD_GRP_DISPLAY) begin
      text_on_o    <= cmd[2];
      graphic_on_o <= cmd[3];
      cursor_on_o  <= cmd[1];
      blink_on_o   <= cmd[0];
    end
  end

  // Data commands: one memory cycle, then step the address pointer, or keep it for the hold commands.
  logic       data_cmd;
  logic       data_wr;
  logic [1:0] step;
  always_comb begin
    data_cmd = 1'b1;
    data_wr  = 1'b0;
    step     = LCD_MEM_STEP_HOLD;
    unique case (cmd)
      LCD_CMD_WR_INC: begin
        data_wr = 1'b1;
        step    = LCD_MEM_STEP_INC;
      end
      LCD_CMD_RD_INC: begin
        step = LCD_MEM_STEP_INC;
      end
      LCD_CMD_WR_DEC: begin
        data_wr = 1'b1;
        step    = LCD_MEM_STEP_DEC;
      end
      LCD_CMD_RD_DEC: begin
        step = LCD_MEM_STEP_DEC;
      end
      LCD_CMD_WR_HOLD: begin
        data_wr = 1'b1;
      end
      LCD_CMD_RD_HOLD: begin
        step = LCD_MEM_STEP_HOLD;
      end
      default: begin
        data_cmd = 1'b0;
      end
    endcase
  end

  logic [1:0] step_q;
  logic       rd_pending_q;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      busy_q       <= 1'b0;
      step_q       <= LCD_MEM_STEP_HOLD;
      rd_pending_q <= 1'b0;
    end else if (cmd_go && data_cmd) begin
      busy_q       <= 1'b1;
      step_q       <= step;
      rd_pending_q <= ~data_wr;
    end else if (mem.done) begin
      busy_q <= 1'b0;
    end
  end

  assign mem.req   = cmd_go & data_cmd;
  assign mem.write = data_wr;
  assign mem.addr  = memory_address_pointer_o;
  assign mem.wdata = op2_q;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      memory_address_pointer_o <= LCD_ADDR_RESET;
    end else if (cmd_go && cmd == LCD_CMD_ADDR) begin
      memory_address_pointer_o <= {op2_q, op1_q};
    end else if (mem.done && busy_q) begin
      unique case (step_q)
        LCD_MEM_STEP_INC: memory_address_pointer_o <= memory_address_pointer_o + 16'h0001;
        LCD_MEM_STEP_DEC: memory_address_pointer_o <= memory_address_pointer_o - 16'h0001;
        default:          memory_address_pointer_o <= memory_address_pointer_o;
      endcase
    end
  end

  // Read data latch and host bus drive; status bit 0 and 1 are the ready flags.
  logic [7:0] read_byte_q;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      read_byte_q <= 8'h00;
    end else if (mem.done && busy_q && rd_pending_q) begin
      read_byte_q <= mem.rdata;
    end
  end

  logic command_ready_flag;
  logic data_ready_flag;
  assign command_ready_flag = ~busy_q;
  assign data_ready_flag    = ~busy_q;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      db_o      <= 8'h00;
      db_oe_n_o <= 1'b1;
    end else begin
      db_oe_n_o <= ~rd_act;
      if (rd_start) begin
        db_o <= is_cmd ? {6'h00, data_ready_flag, command_ready_flag} : read_byte_q;
      end
    end
  end

  lcd_mem_port u_mem_port (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .bus         (mem.mem),
    .ram_we_o    (ram_we_o),
    .ram_re_o    (ram_re_o),
    .ram_addr_o  (ram_addr_o),
    .ram_wdata_o (ram_wdata_o),
    .ram_rdata_i (ram_rdata_i)
  );
endmodule

/* rtl/lcd_mem_if.sv */
// Interface between the command decoder and its display memory port.
`timescale 1ns/1ns
interface lcd_mem_if;
  logic        req;
  logic        write;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  modport ctrl (output req, output write, output addr, output wdata, input done, input rdata);
  modport mem  (input req, input write, input addr, input wdata, output done, output rdata);
endinterface

/* rtl/lcd_mem_port.sv */
// Display memory access sequencer: turns one request into one external RAM cycle.
`timescale 1ns/1ns
module lcd_mem_port
  import lcd_pkg::*;
(
  input  wire logic  clock_i,
  input  wire logic  reset_i,
  lcd_mem_if.mem     bus,
  output logic       ram_we_o,
  output logic       ram_re_o,
  output logic [15:0] ram_addr_o,
  output logic [7:0] ram_wdata_o,
  input  wire logic [7:0] ram_rdata_i
);
  typedef enum logic [1:0] {LCD_MP_IDLE, LCD_MP_ACCESS, LCD_MP_DONE} lcd_mp_state_t;
  lcd_mp_state_t state_q;

  // The RAM is synchronous to clock_i; reads take one cycle, so the decoder catches the byte while done is high.
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_q     <= LCD_MP_IDLE;
      ram_we_o    <= 1'b0;
      ram_re_o    <= 1'b0;
      ram_addr_o  <= LCD_ADDR_RESET;
      ram_wdata_o <= 8'h00;
    end else begin
      unique case (state_q)
        LCD_MP_IDLE: begin
          if (bus.req) begin
            state_q     <= LCD_MP_ACCESS;
            ram_we_o    <= bus.write;
            ram_re_o    <= ~bus.write;
            ram_addr_o  <= bus.addr;
            ram_wdata_o <= bus.wdata;
          end
        end
        LCD_MP_ACCESS: begin
          ram_we_o <= 1'b0;
          ram_re_o <= 1'b0;
          state_q  <= LCD_MP_DONE;
        end
        LCD_MP_DONE: begin
          state_q <= LCD_MP_IDLE;
        end
      endcase
    end
  end

  assign bus.done  = (state_q == LCD_MP_DONE);
  assign bus.rdata = ram_rdata_i;
endmodule

/* rtl/lcd_pkg.sv */
// Package with command codes, field positions and reset values of the command decoder.
package lcd_pkg;
  localparam logic [7:0] LCD_CMD_CURSOR     = 8'h21;
  localparam logic [7:0] LCD_CMD_ADDR       = 8'h24;
  localparam logic [7:0] LCD_CMD_TEXT_HOME  = 8'h40;
  localparam logic [7:0] LCD_CMD_GFX_HOME   = 8'h42;
  localparam logic [7:0] LCD_CMD_WR_INC     = 8'hc0;
  localparam logic [7:0] LCD_CMD_RD_INC     = 8'hc1;
  localparam logic [7:0] LCD_CMD_WR_DEC     = 8'hc2;
  localparam logic [7:0] LCD_CMD_RD_DEC     = 8'hc3;
  localparam logic [7:0] LCD_CMD_WR_HOLD    = 8'hc4;
  localparam logic [7:0] LCD_CMD_RD_HOLD    = 8'hc5;
  localparam logic [3:0] LCD_GRP_MODE_SET   = 4'h8;
  localparam logic [3:0] LCD_GRP_DISPLAY    = 4'h9;
  localparam int         LCD_COLUMN_BITS    = 7;
  localparam int         LCD_ROW_BITS       = 5;
  localparam int         LCD_GLYPH_SRC_BIT  = 3;
  localparam logic [2:0] LCD_MERGE_OR       = 3'h0;
  localparam logic [2:0] LCD_MERGE_XOR      = 3'h1;
  localparam logic [2:0] LCD_MERGE_AND      = 3'h3;
  localparam logic [2:0] LCD_MERGE_ATTR     = 3'h4;
  localparam logic [15:0] LCD_ADDR_RESET    = 16'h0000;
  localparam logic [1:0] LCD_MEM_STEP_HOLD  = 2'h0;
  localparam logic [1:0] LCD_MEM_STEP_INC   = 2'h1;
  localparam logic [1:0] LCD_MEM_STEP_DEC   = 2'h2;
  typedef enum logic [1:0] {LCD_MERGE_MODE_OR, LCD_MERGE_MODE_XOR, LCD_MERGE_MODE_AND, LCD_MERGE_MODE_ATTR} lcd_merge_t;
endpackage

/* tb/lcd_cmd_decoder_bench.sv */
// Self-checking bench: host strobes, command sequences and a display RAM model.
`timescale 1ns/1ns
module lcd_cmd_decoder_bench;
  import lcd_pkg::*;
  logic        clock_i, reset_i, write_n_i, read_n_i, chip_en_n_i, cmd_sel_i;
  logic [7:0]  host_db, db_o, ram_wdata_o, ram_rdata_i, v;
  logic        db_oe_n_o, glyph_generator_ext_o, text_on_o, graphic_on_o, cursor_on_o, blink_on_o;
  logic [6:0]  cursor_column_o;
  logic [4:0]  cursor_row_o;
  logic [15:0] memory_address_pointer_o, text_home_o, graphic_home_o, ram_addr_o;
  lcd_merge_t  merge_mode_o;
  logic        ram_we_o, ram_re_o;
  int          errors, n_compared;
  logic [7:0]  disp_c [4] = '{8'h90, 8'h97, 8'h9a, 8'h9d};
  logic [3:0]  disp_e [4] = '{4'h0, 4'hb, 4'h6, 4'hd};
  logic [7:0]  mode_c [5] = '{8'h80, 8'h89, 8'h8c, 8'h83, 8'h85};
  logic [2:0]  mode_e [5] = '{3'h0, 3'h5, 3'h7, 3'h2, 3'h2};
  // The shared data bus: the decoder's byte while it drives, the host's otherwise.
  wire  [7:0]  db_i = db_oe_n_o ? host_db : db_o;
  lcd_cmd_decoder dut_u (.*);
  lcd_ram_model ram_u (.clock_i(clock_i), .we_i(ram_we_o), .re_i(ram_re_o), .addr_i(ram_addr_o),
                       .wdata_i(ram_wdata_o), .rdata_o(ram_rdata_i));
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic cd, output logic [7:0] r);
    @(posedge clock_i);
    cmd_sel_i <= cd;
    chip_en_n_i <= 1'b0;
    read_n_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    r = db_o;
    read_n_i <= 1'b1;
    chip_en_n_i <= 1'b1;
    repeat (8) @(posedge clock_i);
  endtask
  task automatic poll();
    logic [7:0] s;
    for (int i = 0; i < 30; i++) begin
      rd(1'b1, s);
      if (s[1:0] === 2'b11) return;
    end
    errors++;
    $display("ERROR %0t device never ready", $time);
  endtask
  task automatic wr(input logic cd, input logic [7:0] b);
    poll();
    @(posedge clock_i);
    cmd_sel_i <= cd;
    host_db <= b;
    chip_en_n_i <= 1'b0;
    write_n_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    write_n_i <= 1'b1;
    chip_en_n_i <= 1'b1;
    repeat (8) @(posedge clock_i);
  endtask
  task automatic load2(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    wr(1'b0, a);
    wr(1'b0, b);
    wr(1'b1, c);
  endtask
  initial begin
    errors = 0;
    n_compared = 0;
    reset_i = 1'b1;
    write_n_i = 1'b1;
    read_n_i = 1'b1;
    chip_en_n_i = 1'b1;
    cmd_sel_i = 1'b0;
    host_db = 8'h00;
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    cmp(16'(merge_mode_o), 16'h0000);
    cmp(16'(db_oe_n_o), 16'h0001);
    $display("test reset done");
    wr(1'b0, 8'h11);
    load2(8'h4f, 8'h1f, LCD_CMD_CURSOR);
    cmp(16'(cursor_column_o), 16'h004f);
    cmp(16'(cursor_row_o), 16'h001f);
    load2(8'h34, 8'h12, LCD_CMD_TEXT_HOME);
    cmp(text_home_o, 16'h1234);
    load2(8'h78, 8'h56, LCD_CMD_GFX_HOME);
    cmp(graphic_home_o, 16'h5678);
    cmp(16'(cursor_column_o), 16'h004f);
    $display("test settings done");
    load2(8'h00, 8'h10, LCD_CMD_ADDR);
    wr(1'b0, 8'ha5);
    wr(1'b1, LCD_CMD_WR_INC);
    cmp(memory_address_pointer_o, 16'h1001);
    wr(1'b0, 8'h3c);
    wr(1'b1, LCD_CMD_WR_HOLD);
    cmp(memory_address_pointer_o, 16'h1001);
    wr(1'b1, LCD_CMD_RD_DEC);
    cmp(memory_address_pointer_o, 16'h1000);
    poll();
    rd(1'b0, v);
    cmp(16'(v), 16'h003c);
    wr(1'b1, LCD_CMD_RD_DEC);
    poll();
    rd(1'b0, v);
    cmp(16'(v), 16'h00a5);
    cmp(memory_address_pointer_o, 16'h0fff);
    cmp(16'({cursor_column_o, cursor_row_o}), 16'h09ff);
    $display("test data done");
    for (int i = 0; i < 4; i++) begin
      wr(1'b1, disp_c[i]);
      cmp(16'({text_on_o, graphic_on_o, cursor_on_o, blink_on_o}), 16'(disp_e[i]));
    end
    for (int i = 0; i < 5; i++) begin
      wr(1'b1, mode_c[i]);
      cmp(16'({glyph_generator_ext_o, merge_mode_o}), 16'(mode_e[i]));
    end
    $display("test modes done");
    wr(1'b1, 8'h60);
    cmp(16'({text_on_o, graphic_on_o, cursor_on_o, blink_on_o}), 16'h000d);
    cmp(16'({glyph_generator_ext_o, merge_mode_o}), 16'h0002);
    cmp(memory_address_pointer_o ^ text_home_o, 16'h0fff ^ 16'h1234);
    $display("test unknown done");
    wr(1'b0, 8'h77);
    wr(1'b1, LCD_CMD_WR_DEC);
    cmp(memory_address_pointer_o, 16'h0ffe);
    load2(8'hff, 8'h0f, LCD_CMD_ADDR);
    wr(1'b1, LCD_CMD_RD_HOLD);
    poll();
    rd(1'b0, v);
    cmp(16'(v), 16'h0077);
    cmp(memory_address_pointer_o, 16'h0fff);
    wr(1'b1, LCD_CMD_RD_INC);
    wr(1'b1, LCD_CMD_RD_INC);
    poll();
    rd(1'b0, v);
    cmp(16'(v), 16'h00a5);
    cmp(memory_address_pointer_o, 16'h1001);
    cmp(16'({cursor_column_o, cursor_row_o}), 16'h09ff);
    $display("test steps done");
    summarize();
  end
endmodule

/* tb/lcd_cmd_decoder_chk.sv */
// Port-level checker for the host command decoder.
`timescale 1ns/1ns
module lcd_cmd_decoder_chk (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        write_n_i,
  input  wire logic        read_n_i,
  input  wire logic        db_oe_n_o,
  input  wire logic [6:0]  cursor_column_o,
  input  wire logic [4:0]  cursor_row_o,
  input  wire logic [15:0] memory_address_pointer_o,
  input  wire logic [15:0] text_home_o,
  input  wire logic [15:0] graphic_home_o,
  input  wire logic        ram_we_o,
  input  wire logic        ram_re_o,
  input  wire logic [15:0] ram_addr_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_cursor_data_hold: assert property (ram_we_o || ram_re_o |->
    ##1 ($stable(cursor_column_o) && $stable(cursor_row_o))[*3]) else $error("cursor moved in a data cycle");
  a_write_addr: assert property (ram_we_o |-> ram_addr_o == memory_address_pointer_o)
    else $error("write not at the address pointer");
  a_read_addr: assert property (ram_re_o |-> ram_addr_o == memory_address_pointer_o)
    else $error("read not at the address pointer");
  a_write_step: assert property (ram_we_o |-> ##2
    16'(memory_address_pointer_o - $past(ram_addr_o, 2)) inside {16'h0000, 16'h0001, 16'hffff})
    else $error("pointer stepped wrongly after a write");
  a_read_step: assert property (ram_re_o |-> ##2
    16'(memory_address_pointer_o - $past(ram_addr_o, 2)) inside {16'h0000, 16'h0001, 16'hffff})
    else $error("pointer stepped wrongly after a read");
  a_write_pulse: assert property (ram_we_o |=> !ram_we_o && !ram_re_o)
    else $error("write strobe longer than one cycle");
  a_read_pulse: assert property (ram_re_o |=> !ram_re_o && !ram_we_o)
    else $error("read strobe longer than one cycle");
  a_bus_idle: assert property (read_n_i [*6] |-> db_oe_n_o)
    else $error("data bus driven without a read");
  a_config_quiet: assert property (write_n_i [*8] |-> $stable(text_home_o)
    && $stable(graphic_home_o) && $stable(cursor_column_o)) else $error("setting changed without a command");
endmodule
bind lcd_cmd_decoder lcd_cmd_decoder_chk chk_u (.*);

/* tb/lcd_ram_model.sv */
// Behavioural display RAM answering one-cycle read and write strobes.
`timescale 1ns/1ns
module lcd_ram_model (
  input  wire logic        clock_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o
);
  logic [7:0] mem_q [0:65535];
  logic [1:0] hold_q;
  initial begin
    rdata_o = 8'h5a;
    hold_q = 2'h0;
  end
  always @(posedge clock_i) begin
    if (we_i) mem_q[addr_i] <= wdata_i;
    if (re_i) begin
      rdata_o <= mem_q[addr_i];
      hold_q <= 2'h3;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end else begin
      // Outside a read the byte is not valid, so it must not look stable.
      rdata_o <= ~rdata_o;
    end
  end
endmodule
